// ==== general_purpose_port_logic.sv ====
// general-purpose port logic: port registers, pin muxing and Avalon-MM slave
//
// How it works
// RL1 - port B direction bit one drives the pin, zero leaves it an input
// RL2 - port C data read picks its source per bit from the direction bit
// RL3 - port J input register always returns the synchronised pin level
// RL4 - reduced variant keeps port J direction bits 3-0 only, upper read zero
// RL5 - port S pull enable resets to all ones, package code to PACKAGE_CODE_RESET, all others reset to zero
// RL6 - every port pin is general-purpose I/O; the debug pin is not a port pin
// RL7 - a peripheral select per pin hands the pin to an on-chip peripheral
// RL8 - data read gives pin level for inputs, stored value for outputs
// RL9 - stored data reaches the pin only while it is a general-purpose output
`timescale 1ns/1ps
`include "gpio_defines.svh"

module general_purpose_port_logic
	import gpio_pkg::*;
#(
	parameter bit         REDUCED_VARIANT    = 1'b0,
	parameter int         PORT_WIDTH         = 8,
	parameter port_byte_t PACKAGE_CODE_RESET = 8'h00
) (
	input  wire logic                          mclk,
	input  wire logic                          rst_b,
	// avalon-mm slave
	input  wire logic [11:0]                   address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [31:0]                   writedata,
	input  wire logic [3:0]                    byteenable,
	output logic      [31:0]                   readdata,
	output logic                               waitrequest,
	// pins, one byte per port in order B C T S M P J
	input  wire logic [NUM_PORTS-1:0][7:0]     pin_in,
	output logic      [NUM_PORTS-1:0][7:0]     pin_out,
	output logic      [NUM_PORTS-1:0][7:0]     pin_oe,
	output logic      [NUM_PORTS-1:0][7:0]     pull_up_en,
	output logic      [NUM_PORTS-1:0][7:0]     pull_down_en,
	// peripheral sharing
	input  wire logic [NUM_PORTS-1:0][7:0]     periph_sel,
	input  wire logic [NUM_PORTS-1:0][7:0]     periph_out,
	input  wire logic [NUM_PORTS-1:0][7:0]     periph_oe,
	output logic      [NUM_PORTS-1:0][7:0]     periph_in,
	// storage-only registers and port P change status
	output logic      [7:0]                    pin_routing_select,
	output logic      [7:0]                    package_code,
	output logic                               port_p_change_pending
);

	// ==========================================
	// elaboration checks
	if (PORT_WIDTH != `GP_PORT_WIDTH) begin : g_width_check
		$error("port logic serves only 8-bit ports");
	end

	// ==========================================
	// register storage
	port_byte_t data_reg   [NUM_PORTS];
	port_byte_t dir_reg    [NUM_PORTS];
	port_byte_t pull_reg   [NUM_PORTS];
	port_byte_t pol_reg    [NUM_PORTS];
	port_byte_t wom_reg    [NUM_PORTS];
	port_byte_t sync_1     [NUM_PORTS];
	port_byte_t sync_2     [NUM_PORTS];
	port_byte_t p_level_d;
	port_byte_t p_irq_en;
	port_byte_t p_irq_flag;
	port_byte_t next_p_irq_flag;
	port_byte_t p_edge;
	port_byte_t j_dir_mask;
	port_byte_t wr_byte;
	port_byte_t next_readdata;

	// ==========================================
	// address decode
	logic [9:0] index;
	logic       hit;
	int         sel;
	reg_kind_t  kind;
	logic       ack;
	logic       wr_en;

	assign index      = address[`GP_INDEX_MSB:`GP_INDEX_LSB];
	assign wr_byte    = writedata[7:0];
	assign j_dir_mask = REDUCED_VARIANT ? `GP_J_DIR_MASK_RED : `GP_J_DIR_MASK_FULL;

	always_comb begin
		hit  = 1'b1;
		sel  = PORT_B;
		kind = KIND_NONE;
		unique case (index)
			`GP_T_DATA:   begin sel = PORT_T; kind = KIND_DATA; end
			`GP_T_PIN:    begin sel = PORT_T; kind = KIND_PIN;  end
			`GP_T_DIR:    begin sel = PORT_T; kind = KIND_DIR;  end
			`GP_T_RSVD_A: kind = KIND_RSVD;
			`GP_T_PULL:   begin sel = PORT_T; kind = KIND_PULL; end
			`GP_T_POL:    begin sel = PORT_T; kind = KIND_POL;  end
			`GP_T_RSVD_B: kind = KIND_RSVD;
			`GP_T_RSVD_C: kind = KIND_RSVD;
			`GP_S_DATA:   begin sel = PORT_S; kind = KIND_DATA; end
			`GP_S_PIN:    begin sel = PORT_S; kind = KIND_PIN;  end
			`GP_S_DIR:    begin sel = PORT_S; kind = KIND_DIR;  end
			`GP_S_RSVD:   kind = KIND_RSVD;
			`GP_S_PULL:   begin sel = PORT_S; kind = KIND_PULL; end
			`GP_S_POL:    begin sel = PORT_S; kind = KIND_POL;  end
			`GP_S_WOM:    begin sel = PORT_S; kind = KIND_WOM;  end
			`GP_ROUTE:    kind = KIND_ROUTE;
			`GP_M_DATA:   begin sel = PORT_M; kind = KIND_DATA; end
			`GP_M_PIN:    begin sel = PORT_M; kind = KIND_PIN;  end
			`GP_M_DIR:    begin sel = PORT_M; kind = KIND_DIR;  end
			`GP_M_RSVD:   kind = KIND_RSVD;
			`GP_M_PULL:   begin sel = PORT_M; kind = KIND_PULL; end
			`GP_M_POL:    begin sel = PORT_M; kind = KIND_POL;  end
			`GP_M_WOM:    begin sel = PORT_M; kind = KIND_WOM;  end
			`GP_PKG:      kind = KIND_PKG;
			`GP_P_DATA:   begin sel = PORT_P; kind = KIND_DATA; end
			`GP_P_PIN:    begin sel = PORT_P; kind = KIND_PIN;  end
			`GP_P_DIR:    begin sel = PORT_P; kind = KIND_DIR;  end
			`GP_P_RSVD:   kind = KIND_RSVD;
			`GP_P_PULL:   begin sel = PORT_P; kind = KIND_PULL; end
			`GP_P_POL:    begin sel = PORT_P; kind = KIND_POL;  end
			`GP_P_IE:     kind = KIND_IE;
			`GP_P_IF:     kind = KIND_IF;
			`GP_J_DATA:   begin sel = PORT_J; kind = KIND_DATA; end
			`GP_J_PIN:    begin sel = PORT_J; kind = KIND_PIN;  end
			`GP_J_DIR:    begin sel = PORT_J; kind = KIND_DIR;  end
			`GP_J_PULL:   begin sel = PORT_J; kind = KIND_PULL; end
			`GP_J_POL:    begin sel = PORT_J; kind = KIND_POL;  end
			`GP_B_DATA:   begin sel = PORT_B; kind = KIND_DATA; end
			`GP_B_DIR:    begin sel = PORT_B; kind = KIND_DIR;  end
			`GP_C_DATA:   begin sel = PORT_C; kind = KIND_DATA; end
			`GP_C_DIR:    begin sel = PORT_C; kind = KIND_DIR;  end
			`GP_C_PULL:   begin sel = PORT_C; kind = KIND_PULL; end
			default:      hit = 1'b0;
		endcase
		// misaligned byte addresses are treated as unmapped
		if (address[1:0] != 2'b00) begin
			hit  = 1'b0;
			kind = KIND_NONE;
		end
	end

	// ==========================================
	// bus handshake: one wait state on every access
	// the extra cycle lets read data come straight from a flip-flop
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
		end else begin
			ack <= (read | write) & ~ack;
		end
	end

	assign waitrequest = (read | write) & ~ack;
	// writes take effect at the edge where waitrequest is seen low
	assign wr_en = write & ack & hit & byteenable[0];

	// ==========================================
	// read data mux
	always_comb begin
		next_readdata = 8'h00;
		unique case (kind)
			KIND_DATA: begin
				// per bit: outputs read back the latch, inputs read the pin
				next_readdata = (dir_reg[sel] & data_reg[sel])
					| (~dir_reg[sel] & sync_2[sel]); // RL2 RL8
			end
			KIND_PIN:   next_readdata = sync_2[sel]; // RL3
			KIND_DIR:   next_readdata = dir_reg[sel];
			KIND_PULL:  next_readdata = pull_reg[sel];
			KIND_POL:   next_readdata = pol_reg[sel];
			KIND_WOM:   next_readdata = wom_reg[sel];
			KIND_ROUTE: next_readdata = pin_routing_select;
			KIND_PKG:   next_readdata = package_code;
			KIND_IE:    next_readdata = p_irq_en;
			KIND_IF:    next_readdata = p_irq_flag;
			KIND_RSVD:  next_readdata = 8'h00;
			KIND_NONE:  next_readdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ack) begin
			readdata <= {24'h00_0000, next_readdata};
		end
	end

	// ==========================================
	// data and direction registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				data_reg[i] <= `GP_RESET_ZERO; // RL5
			end
		end else if (wr_en && kind == KIND_DATA) begin
			data_reg[sel] <= wr_byte; // RL9
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				dir_reg[i] <= `GP_RESET_ZERO; // RL4 RL5
			end
		end else if (wr_en && kind == KIND_DIR) begin
			if (sel == PORT_J) begin
				dir_reg[sel] <= wr_byte & j_dir_mask; // RL4
			end else begin
				dir_reg[sel] <= wr_byte; // RL1
			end
		end
	end

	// ==========================================
	// pull, polarity and wired-or registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				pull_reg[i] <= (i == PORT_S) ? `GP_RESET_S_PULL : `GP_RESET_ZERO; // RL5
			end
		end else if (wr_en && kind == KIND_PULL) begin
			pull_reg[sel] <= wr_byte;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				pol_reg[i] <= `GP_RESET_ZERO; // RL5
			end
		end else if (wr_en && kind == KIND_POL) begin
			pol_reg[sel] <= wr_byte;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				wom_reg[i] <= `GP_RESET_ZERO; // RL5
			end
		end else if (wr_en && kind == KIND_WOM) begin
			wom_reg[sel] <= wr_byte;
		end
	end

	// ==========================================
	// storage-only registers
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_routing_select <= `GP_RESET_ZERO;
		end else if (wr_en && kind == KIND_ROUTE) begin
			pin_routing_select <= wr_byte;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			package_code <= PACKAGE_CODE_RESET;
		end else if (wr_en && kind == KIND_PKG) begin
			package_code <= wr_byte;
		end
	end

	// ==========================================
	// port P pin-change flags
	// active edge follows the polarity bit: falling for zero, rising for one
	assign p_edge = (pol_reg[PORT_P] & sync_2[PORT_P] & ~p_level_d)
		| (~pol_reg[PORT_P] & ~sync_2[PORT_P] & p_level_d);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			p_irq_en <= `GP_RESET_ZERO;
		end else if (wr_en && kind == KIND_IE) begin
			p_irq_en <= wr_byte;
		end
	end

	always_comb begin
		next_p_irq_flag = p_irq_flag;
		if (wr_en && kind == KIND_IF) begin
			next_p_irq_flag = p_irq_flag & ~wr_byte;
		end
		// a new edge in the clearing cycle is kept
		next_p_irq_flag = next_p_irq_flag | p_edge;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			p_irq_flag <= `GP_RESET_ZERO;
		end else begin
			p_irq_flag <= next_p_irq_flag;
		end
	end

	// resets like the synchroniser, so no false edge follows reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			p_level_d <= `GP_RESET_ZERO;
		end else begin
			p_level_d <= sync_2[PORT_P];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			port_p_change_pending <= 1'b0;
		end else begin
			port_p_change_pending <= |(p_irq_flag & p_irq_en);
		end
	end

	// ==========================================
	// per-port pin logic
	// the debug pin is not among these ports, so it never sees port control
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		port_byte_t gp_oe;
		port_byte_t next_oe;
		port_byte_t next_out;
		port_byte_t pull_on;

		// wired-or pins drive only low; a one leaves the pin to its pull
		assign gp_oe    = dir_reg[g] & ~(wom_reg[g] & data_reg[g]); // RL1 RL6
		assign next_oe  = (periph_sel[g] & periph_oe[g]) | (~periph_sel[g] & gp_oe); // RL7
		assign next_out = (periph_sel[g] & periph_out[g])
			| (~periph_sel[g] & data_reg[g]); // RL7 RL9
		// a pull never fights a driving output
		assign pull_on  = pull_reg[g] & ~next_oe;

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				sync_1[g] <= `GP_RESET_ZERO;
				sync_2[g] <= `GP_RESET_ZERO;
			end else begin
				sync_1[g] <= pin_in[g];
				sync_2[g] <= sync_1[g];
			end
		end

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				pin_out[g] <= `GP_RESET_ZERO;
			end else begin
				pin_out[g] <= next_out;
			end
		end

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				pin_oe[g] <= `GP_RESET_ZERO;
			end else begin
				pin_oe[g] <= next_oe;
			end
		end

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				pull_up_en[g] <= `GP_RESET_ZERO;
			end else begin
				pull_up_en[g] <= pull_on & ~pol_reg[g];
			end
		end

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				pull_down_en[g] <= `GP_RESET_ZERO;
			end else begin
				pull_down_en[g] <= pull_on & pol_reg[g];
			end
		end

		assign periph_in[g] = sync_2[g]; // RL7
	end

endmodule // general_purpose_port_logic

// ==== gpio_defines.svh ====
// register indices, reset values and widths of the general-purpose port logic
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH

// ==========================================
// register indices (byte address is four times the index)
`define GP_T_DATA      10'h240
`define GP_T_PIN       10'h241
`define GP_T_DIR       10'h242
`define GP_T_RSVD_A    10'h243
`define GP_T_PULL      10'h244
`define GP_T_POL       10'h245
`define GP_T_RSVD_B    10'h246
`define GP_T_RSVD_C    10'h247
`define GP_S_DATA      10'h248
`define GP_S_PIN       10'h249
`define GP_S_DIR       10'h24a
`define GP_S_RSVD      10'h24b
`define GP_S_PULL      10'h24c
`define GP_S_POL       10'h24d
`define GP_S_WOM       10'h24e
`define GP_ROUTE       10'h24f
`define GP_M_DATA      10'h250
`define GP_M_PIN       10'h251
`define GP_M_DIR       10'h252
`define GP_M_RSVD      10'h253
`define GP_M_PULL      10'h254
`define GP_M_POL       10'h255
`define GP_M_WOM       10'h256
`define GP_PKG         10'h257
`define GP_P_DATA      10'h258
`define GP_P_PIN       10'h259
`define GP_P_DIR       10'h25a
`define GP_P_RSVD      10'h25b
`define GP_P_PULL      10'h25c
`define GP_P_POL       10'h25d
`define GP_P_IE        10'h25e
`define GP_P_IF        10'h25f
`define GP_J_DATA      10'h268
`define GP_J_PIN       10'h269
`define GP_J_DIR       10'h26a
`define GP_J_PULL      10'h26b
`define GP_J_POL       10'h26c
`define GP_B_DATA      10'h270
`define GP_B_DIR       10'h271
`define GP_C_DATA      10'h272
`define GP_C_DIR       10'h273
`define GP_C_PULL      10'h274

// ==========================================
// reset values and field widths
`define GP_RESET_ZERO       8'h00
`define GP_RESET_S_PULL     8'hff
`define GP_J_DIR_MASK_RED   8'h0f
`define GP_J_DIR_MASK_FULL  8'hff
`define GP_PORT_WIDTH       8
`define GP_INDEX_MSB        11
`define GP_INDEX_LSB        2

`endif

// ==== gpio_pkg.sv ====
// types shared by the general-purpose port logic
package gpio_pkg;

	// ==========================================
	// port numbering and register kinds
	localparam int NUM_PORTS = 7;
	localparam int PORT_B    = 0;
	localparam int PORT_C    = 1;
	localparam int PORT_T    = 2;
	localparam int PORT_S    = 3;
	localparam int PORT_M    = 4;
	localparam int PORT_P    = 5;
	localparam int PORT_J    = 6;

	typedef logic [7:0] port_byte_t;

	typedef enum logic [3:0] {
		KIND_NONE,
		KIND_DATA,
		KIND_PIN,
		KIND_DIR,
		KIND_PULL,
		KIND_POL,
		KIND_WOM,
		KIND_ROUTE,
		KIND_PKG,
		KIND_IE,
		KIND_IF,
		KIND_RSVD
	} reg_kind_t;

endpackage

// ==== gpio_port_chk.sv ====
// concurrent checks on the ports of the general-purpose port logic
`timescale 1ns/1ps
module gpio_port_chk
	import gpio_pkg::*;
(
	input wire logic                      mclk,
	input wire logic                      rst_b,
	input wire logic                      read,
	input wire logic                      write,
	input wire logic [31:0]               readdata,
	input wire logic                      waitrequest,
	input wire logic [NUM_PORTS-1:0][7:0] pin_in,
	input wire logic [NUM_PORTS-1:0][7:0] pin_out,
	input wire logic [NUM_PORTS-1:0][7:0] pin_oe,
	input wire logic [NUM_PORTS-1:0][7:0] pull_up_en,
	input wire logic [NUM_PORTS-1:0][7:0] pull_down_en,
	input wire logic [NUM_PORTS-1:0][7:0] periph_sel,
	input wire logic [NUM_PORTS-1:0][7:0] periph_out,
	input wire logic [NUM_PORTS-1:0][7:0] periph_in
);
	// ==========================================
	// settle flags: $past still sees values from before reset
	logic [1:0] up;
	wire        req = read | write;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) up <= 2'h0;
		else up <= {up[0], 1'b1};
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// ==========================================
	// properties
	property p_reset;
		$rose(rst_b) |-> pin_oe == '0 && pin_out == '0
			##1 pull_up_en[PORT_S] == 8'hff && pull_up_en[PORT_T] == 8'h00;
	endproperty
	property p_wait; $rose(req) |-> waitrequest ##1 !waitrequest; endproperty
	property p_idle; !req |-> !waitrequest; endproperty
	property p_rearm; req && !waitrequest ##1 req |-> waitrequest; endproperty
	property p_hi; readdata[31:8] == 24'h000000; endproperty
	property p_hold; !read |=> $stable(readdata); endproperty
	property p_sync; up[1] |-> periph_in == $past(pin_in, 2); endproperty
	property p_periph;
		up[0] |-> (pin_out & $past(periph_sel)) == $past(periph_out & periph_sel);
	endproperty
	property p_pull;
		((pull_up_en | pull_down_en) & pin_oe) == '0 && (pull_up_en & pull_down_en) == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");
	a_wait: assert property (p_wait) else $error("wait state wrong");
	a_idle: assert property (p_idle) else $error("wait without request");
	a_rearm: assert property (p_rearm) else $error("wait not raised again");
	a_hi: assert property (p_hi) else $error("upper read data not zero");
	a_hold: assert property (p_hold) else $error("read data changed");
	a_sync: assert property (p_sync) else $error("pin level delay wrong");
	a_periph: assert property (p_periph) else $error("peripheral drive lost");
	a_pull: assert property (p_pull) else $error("pull on driven pin");
	c_rd: cover property (read && !waitrequest);
	c_wr: cover property (write && !waitrequest);
	c_sel: cover property (|periph_sel);
endmodule // gpio_port_chk

bind general_purpose_port_logic gpio_port_chk gpio_port_chk_inst (.*);

// ==== gpio_pin_model.sv ====
// pin model: external drivers, pulls and floating lines of all ports
`timescale 1ns/1ps
module gpio_pin_model
	import gpio_pkg::*;
(
	input wire logic                      mclk,
	input wire logic [NUM_PORTS-1:0][7:0] pin_out,
	input wire logic [NUM_PORTS-1:0][7:0] pin_oe,
	input wire logic [NUM_PORTS-1:0][7:0] pull_up_en,
	input wire logic [NUM_PORTS-1:0][7:0] pull_down_en,
	input wire logic [NUM_PORTS-1:0][7:0] ext_val,
	input wire logic [NUM_PORTS-1:0][7:0] ext_oe,
	output logic     [NUM_PORTS-1:0][7:0] pin_in
);
	// ==========================================
	// an external driver overpowers the pin driver, as a short would;
	// an undriven, unpulled line toggles so it never reads as a stable value
	logic [7:0] flt = 8'h55;
	always_ff @(posedge mclk) flt <= ~flt;
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			pin_in[p] = (ext_oe[p] & ext_val[p]) | (~ext_oe[p] & pin_oe[p] & pin_out[p])
				| (~ext_oe[p] & ~pin_oe[p] & (pull_up_en[p] | (~pull_down_en[p] & flt)));
		end
	end
endmodule // gpio_pin_model

// ==== general_purpose_port_logic_tb.sv ====
// self-checking testbench of the general-purpose port logic
`timescale 1ns/1ps
`include "gpio_defines.svh"
module general_purpose_port_logic_tb
	import gpio_pkg::*;
;
	typedef logic [NUM_PORTS-1:0][7:0] pins_t;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [11:0] address = 12'h000;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0]  byteenable = 4'hf;
	logic [31:0] readdata;
	logic        waitrequest;
	pins_t       pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, periph_in;
	// pins held high from outside so floating lines cannot raise port P flags
	pins_t       periph_sel = '0, periph_out = '0, periph_oe = '0, ext_val = '1, ext_oe = '1;
	logic [1:0]  low_bits = 2'h0;
	logic [7:0]  pin_routing_select, package_code;
	logic        port_p_change_pending;
	int          n_fail = 0, checks_done = 0;
	port_byte_t  rd;

	always #50 mclk = ~mclk;
	general_purpose_port_logic #(.REDUCED_VARIANT(1'b1)) general_purpose_port_logic_inst (.*);
	gpio_pin_model gpio_pin_model_inst (.*);

	// ==========================================
	// bus and compare tasks
	task automatic check(input string nm, input port_byte_t seen, input port_byte_t exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [9:0] idx, input port_byte_t d,
		input logic [3:0] be);
		@(posedge mclk);
		address <= {idx, low_bits};
		writedata <= {24'h000000, d};
		byteenable <= be;
		read <= !w;
		write <= w;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		rd = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input port_byte_t d);
		bus(1'b1, idx, d, 4'hf);
	endtask
	task automatic rdc(input string nm, input logic [9:0] idx, input port_byte_t exp);
		bus(1'b0, idx, 8'h00, 4'hf);
		check(nm, rd, exp);
	endtask
	// outputs are looked at mid-cycle, after the pin path has settled
	task automatic pause;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// scenarios
	task automatic reset_check;
		logic [9:0] idx [29] = '{`GP_T_DIR, `GP_T_RSVD_A, `GP_T_PULL, `GP_T_POL, `GP_T_RSVD_B,
			`GP_T_RSVD_C, `GP_S_DIR, `GP_S_RSVD, `GP_S_POL, `GP_S_WOM, `GP_ROUTE, `GP_M_DIR,
			`GP_M_RSVD, `GP_M_PULL, `GP_M_POL, `GP_M_WOM, `GP_PKG, `GP_P_DIR, `GP_P_RSVD,
			`GP_P_PULL, `GP_P_POL, `GP_P_IE, `GP_P_IF, `GP_J_DIR, `GP_J_PULL, `GP_J_POL,
			`GP_B_DIR, `GP_C_DIR, `GP_C_PULL};
		foreach (idx[i]) rdc("reset value", idx[i], 8'h00);
		rdc("port s pull reset", `GP_S_PULL, 8'hff);
		check("port s pull up", pull_up_en[PORT_S], 8'hff);
		$display("test reset done");
	endtask
	task automatic port_io(input int p, input logic [9:0] dat, input logic [9:0] dir);
		@(posedge mclk);
		ext_oe[p] <= 8'h0f;
		ext_val[p] <= 8'h0a;
		wr(dat, 8'h3c);
		pause;
		check("stored only", pin_oe[p], 8'h00);
		wr(dir, 8'hf0);
		pause;
		check("direction", pin_oe[p], 8'hf0);
		check("drive", pin_out[p] & 8'hf0, 8'h30);
		rdc("data mix", dat, 8'h3a);
		wr(dir, 8'h00);
		@(posedge mclk);
		ext_oe[p] <= 8'hff;
		ext_val[p] <= 8'hff;
		$display("test port %0d done", p);
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		reset_check;
		bus(1'b1, `GP_T_POL, 8'hff, 4'h0);
		rdc("no byte enable", `GP_T_POL, 8'h00);
		wr(`GP_T_RSVD_A, 8'hff);
		rdc("reserved", `GP_T_RSVD_A, 8'h00);
		wr(10'h3f0, 8'hff);
		rdc("unmapped", 10'h3f0, 8'h00);
		wr(`GP_T_POL, 8'h5a);
		rdc("read write", `GP_T_POL, 8'h5a);
		low_bits = 2'h1;
		wr(`GP_T_POL, 8'h00);
		rdc("misaligned read", `GP_T_POL, 8'h00);
		low_bits = 2'h0;
		rdc("misaligned write", `GP_T_POL, 8'h5a);
		$display("test access done");
		port_io(PORT_B, `GP_B_DATA, `GP_B_DIR);
		port_io(PORT_C, `GP_C_DATA, `GP_C_DIR);
		port_io(PORT_T, `GP_T_DATA, `GP_T_DIR);
		port_io(PORT_S, `GP_S_DATA, `GP_S_DIR);
		port_io(PORT_M, `GP_M_DATA, `GP_M_DIR);
		port_io(PORT_P, `GP_P_DATA, `GP_P_DIR);
		@(posedge mclk);
		ext_oe[PORT_J] <= 8'hf1;
		ext_val[PORT_J] <= 8'h50;
		wr(`GP_J_DIR, 8'hff);
		rdc("reduced direction", `GP_J_DIR, 8'h0f);
		wr(`GP_J_DATA, 8'h0f);
		pause;
		check("reduced drive", pin_oe[PORT_J], 8'h0f);
		rdc("pin level", `GP_J_PIN, 8'h5e);
		rdc("data level", `GP_J_DATA, 8'h5f);
		$display("test port j done");
		wr(`GP_S_DIR, 8'hff);
		wr(`GP_S_DATA, 8'h0f);
		wr(`GP_S_WOM, 8'h0f);
		pause;
		check("wired-or drive", pin_oe[PORT_S], 8'hf0);
		check("pull on released", pull_up_en[PORT_S], 8'h0f);
		@(posedge mclk);
		periph_sel[PORT_T] <= 8'hff;
		periph_out[PORT_T] <= 8'h5a;
		periph_oe[PORT_T] <= 8'h3c;
		pause;
		check("peripheral out", pin_out[PORT_T], 8'h5a);
		check("peripheral oe", pin_oe[PORT_T], 8'h3c);
		@(posedge mclk);
		periph_sel[PORT_T] <= 8'h00;
		$display("test peripheral done");
		wr(`GP_P_IF, 8'hff);
		wr(`GP_P_IE, 8'h01);
		rdc("flags cleared", `GP_P_IF, 8'h00);
		@(posedge mclk);
		ext_val[PORT_P] <= 8'hfe;
		pause;
		rdc("change flag", `GP_P_IF, 8'h01);
		check("pending", {7'h00, port_p_change_pending}, 8'h01);
		wr(`GP_P_IF, 8'h01);
		rdc("flag cleared", `GP_P_IF, 8'h00);
		check("pending cleared", {7'h00, port_p_change_pending}, 8'h00);
		@(posedge mclk);
		ext_val[PORT_P] <= 8'hff;
		wr(`GP_ROUTE, 8'ha5);
		wr(`GP_PKG, 8'h3c);
		@(negedge mclk);
		check("routing out", pin_routing_select, 8'ha5);
		check("package out", package_code, 8'h3c);
		$display("test port p flags done");
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		reset_check;
		complete_run;
	end

	// a hang counts as a mismatch
	initial begin
		repeat (6000) @(posedge mclk);
		n_fail++;
		complete_run;
	end
endmodule // general_purpose_port_logic_tb
